// ===== rtl/clock_gating_and_oscillator_ctrl.sv
// Peripheral clock gating and oscillator control
`timescale 1ns/10ps
`default_nettype none
module clock_gating_and_oscillator_ctrl
	import clk_ctrl_pkg::*;
#(
	parameter int STAB_UNIT = STAB_UNIT_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       stop_exec,
	input  wire logic       wake_req,
	input  wire logic       subsys_osc_in,
	input  wire logic       subsys_osc_out,
	output logic            stop_mode,
	output logic            main_osc_enable,
	output logic            main_ext_clk_gate,
	output logic            int_hs_osc_enable,
	output logic            subsys_osc_enable,
	output logic      [1:0] cpu_source,
	output logic      [1:0] subsys_pin_port_in,
	output logic      [7:0] periph_clk_gate,
	output logic            periph_on_subclk,
	output logic            adc_i2c_unguaranteed
);

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [1:0] {
		PM_RUN  = 2'b00,
		PM_STOP = 2'b01,
		PM_WAIT = 2'b10
	} pm_state_t;

	typedef struct packed {
		per_en_t    per_en;
		osc_mode_t  osc_mode;
		logic [7:0] op_stat;
		logic       main_sel_req;
		logic       sub_sel_req;
		cpu_src_t   src;
		logic [2:0] stab_sel;
		pm_state_t  pm;
		logic [7:0] rdata;
		logic [1:0] pin_s1;
		logic [1:0] pin_s2;
	} state_t;

	state_t q, d;

	logic     stab_start;
	logic     stab_done;
	reg_req_t req;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr,
		rd: reg_rd};

	stab_timer #(
		.UNIT_CYC (STAB_UNIT)
	) u_stab (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.start   (stab_start),
		.sel     (q.stab_sel),
		.done    (stab_done)
	);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		d = q;
		stab_start = 1'b0;
		// Pins are asynchronous; two flops before anything looks at them
		d.pin_s1 = {subsys_osc_out, subsys_osc_in};
		d.pin_s2 = q.pin_s1;

		if (req.wr) begin
			unique case (req.addr)
				ADDR_PER_EN:   d.per_en   = per_en_t'(req.wdata);
				ADDR_OSC_MODE: d.osc_mode = osc_mode_t'(req.wdata);
				ADDR_OP_STAT:  d.op_stat  = req.wdata & OP_STAT_RESET
					| {7'h00, req.wdata[HIO_STOP_BIT]};
				ADDR_CPU_CLK: begin
					d.sub_sel_req  = req.wdata[SUB_SEL_REQ_BIT];
					d.main_sel_req = req.wdata[MAIN_SEL_REQ_BIT];
				end
				ADDR_STAB_SEL: d.stab_sel = req.wdata[2:0];
				default: ;
			endcase
		end

		// Source switch only to a running clock; refuse otherwise
		if (q.sub_sel_req && !q.op_stat[SUB_STOP_BIT]
			&& q.osc_mode.subsys_pin_select) begin
			d.src = SRC_SUB;
		end else if (q.main_sel_req && !q.op_stat[MAIN_STOP_BIT]
			&& q.pm == PM_RUN) begin
			d.src = SRC_MAIN_HS;
		end else if (!q.op_stat[HIO_STOP_BIT]) begin
			d.src = SRC_INT_HS;
		end

		// Internal oscillator stop is cleared one cycle after it is set while the CPU runs on it
		if (q.src == SRC_INT_HS && q.op_stat[HIO_STOP_BIT]) begin
			d.op_stat[HIO_STOP_BIT] = 1'b0;
		end

		unique case (q.pm)
			PM_RUN: begin
				if (stop_exec) begin
					d.pm = PM_STOP;
				end
			end
			PM_STOP: begin
				if (wake_req) begin
					d.pm = PM_WAIT;
					stab_start = 1'b1;
				end
			end
			PM_WAIT: begin
				if (stab_done) begin
					d.pm = PM_RUN;
				end
			end
			default: d.pm = PM_RUN;
		endcase

		d.rdata = 8'h00;
		if (req.rd) begin
			unique case (req.addr)
				ADDR_PER_EN:   d.rdata = q.per_en;
				ADDR_OSC_MODE: d.rdata = q.osc_mode;
				ADDR_OP_STAT:  d.rdata = q.op_stat;
				ADDR_CPU_CLK:  d.rdata = {q.src == SRC_SUB, q.sub_sel_req,
					q.src == SRC_MAIN_HS, q.main_sel_req, 4'h0};
				ADDR_STAB_SEL: d.rdata = {5'h00, q.stab_sel};
				default:       d.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			q          <= '0;
			q.per_en   <= per_en_t'(PER_EN_RESET);
			q.osc_mode <= osc_mode_t'(OSC_MODE_RESET);
			q.op_stat  <= OP_STAT_RESET;
			q.stab_sel <= STAB_SEL_RESET[2:0];
			q.src      <= SRC_INT_HS;
			q.pm       <= PM_RUN;
		end else begin
			q <= d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	logic main_run;
	assign main_run = !q.op_stat[MAIN_STOP_BIT] && q.pm != PM_STOP;

	assign reg_rdata         = q.rdata;
	assign stop_mode         = (q.pm == PM_STOP);
	assign main_osc_enable   = main_run && !q.osc_mode.ext_clock_select
		&& q.osc_mode.main_pin_select;
	assign main_ext_clk_gate = main_run && q.osc_mode.ext_clock_select;
	assign int_hs_osc_enable = !q.op_stat[HIO_STOP_BIT];
	// Needs pin select and stop bit clear; fixed bits are not checked
	assign subsys_osc_enable = q.osc_mode.subsys_pin_select
		&& !q.op_stat[SUB_STOP_BIT];
	assign cpu_source        = q.src;
	// Pins read as port inputs unless claimed by the oscillator
	assign subsys_pin_port_in = q.osc_mode.subsys_pin_select ? 2'b00
		: q.pin_s2;
	assign periph_clk_gate   = q.per_en;
	assign periph_on_subclk  = (q.src == SRC_SUB);
	assign adc_i2c_unguaranteed = (q.src == SRC_SUB) &&
		(q.per_en.adc || q.per_en.i2c);

endmodule : clock_gating_and_oscillator_ctrl
`default_nettype wire

// ===== pkg/clk_ctrl_pkg.sv
// Constants and carriers for the clock gating and oscillator control block
// Operation
// - A peripheral clock enable bit at 0 cuts that unit's input clock and at 1 supplies it.
// - The enable register holds, from bit 7 down, real-time counter, D/A, A/D, I2C, serial 1, serial 0, timer 1, timer 0.
// - The stop instruction enters stop mode and halts the main crystal or blocks the external clock input.
// - Status reports the CPU source: both selects 0 internal, main select 1 high-speed, subsystem select 1 subsystem.
// - The internal high-speed oscillator stop bit at 1 stops the internal high-speed clock.
// - After reset both subsystem oscillator pins are in input port mode.
// - With the subsystem clock unused the two subsystem pins serve as general input pins.
// - When the subsystem clock runs the CPU it also clocks peripherals, except the listed ones; A/D and I2C unguaranteed.
// - Clearing the subsystem oscillator stop bit to 0 starts the subsystem crystal oscillator; the code starts it only with the subsystem pin select bit also set.
package clk_ctrl_pkg;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [3:0] ADDR_PER_EN   = 4'h0;
	localparam logic [3:0] ADDR_OSC_MODE = 4'h1;
	localparam logic [3:0] ADDR_OP_STAT  = 4'h2;
	localparam logic [3:0] ADDR_CPU_CLK  = 4'h3;
	localparam logic [3:0] ADDR_STAB_SEL = 4'h4;

	localparam logic [7:0] PER_EN_RESET   = 8'h00;
	localparam logic [7:0] OSC_MODE_RESET = 8'h00;
	localparam logic [7:0] OP_STAT_RESET  = 8'hc0;
	localparam logic [7:0] STAB_SEL_RESET = 8'h07;

	// Clock operation status/control fields
	localparam int MAIN_STOP_BIT = 7;
	localparam int SUB_STOP_BIT  = 6;
	localparam int HIO_STOP_BIT  = 0;

	// CPU clock control fields
	localparam int SUB_SEL_STAT_BIT  = 7;
	localparam int MAIN_SEL_STAT_BIT = 5;
	localparam int SUB_SEL_REQ_BIT   = 6;
	localparam int MAIN_SEL_REQ_BIT  = 4;

	// Peripheral enable bit positions
	localparam int RTC_BIT    = 7;
	localparam int DAC_BIT    = 6;
	localparam int ADC_BIT    = 5;
	localparam int I2C_BIT    = 4;
	localparam int SER1_BIT   = 3;
	localparam int SER0_BIT   = 2;
	localparam int TMR1_BIT   = 1;
	localparam int TMR0_BIT   = 0;

	// Stabilization wait unit: one tick per this many clocks
	localparam int STAB_UNIT_CYC = 256;

	typedef enum logic [1:0] {
		SRC_INT_HS  = 2'b00,
		SRC_MAIN_HS = 2'b01,
		SRC_SUB     = 2'b10
	} cpu_src_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic rtc;
		logic dac;
		logic adc;
		logic i2c;
		logic ser1;
		logic ser0;
		logic tmr1;
		logic tmr0;
	} per_en_t;

	typedef struct packed {
		logic ext_clock_select;
		logic main_pin_select;
		logic fixed5;
		logic subsys_pin_select;
		logic fixed3;
		logic subsys_drive_hi;
		logic subsys_drive_lo;
		logic main_freq_range;
	} osc_mode_t;

endpackage : clk_ctrl_pkg

// ===== rtl/stab_timer.sv
// Oscillation stabilization wait counter
`timescale 1ns/10ps
`default_nettype none
module stab_timer
	import clk_ctrl_pkg::*;
#(
	parameter int UNIT_CYC = STAB_UNIT_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       reset_n,
	input  wire logic       start,
	input  wire logic [2:0] sel,
	output logic            done
);

	typedef struct packed {
		logic [15:0] unit;
		logic [15:0] cnt;
		logic        busy;
		logic        done;
	} st_t;

	st_t q, d;

	// Wait length doubles per select step
	function automatic logic [15:0] wait_len(input logic [2:0] s);
		wait_len = 16'h0001 << s;
	endfunction : wait_len

	logic tick;

	assign tick = (q.unit == 16'(UNIT_CYC - 1));

	always_comb begin
		d = q;
		d.done = 1'b0;
		// Unit divider idles at zero so every wait starts on a full unit
		d.unit = (!q.busy || tick) ? 16'h0000 : q.unit + 16'h0001;
		if (start) begin
			d.busy = 1'b1;
			d.cnt  = wait_len(sel);
		end else if (q.busy && tick) begin
			if (q.cnt == 16'h0001) begin
				d.busy = 1'b0;
				d.done = 1'b1;
			end
			d.cnt = q.cnt - 16'h0001;
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done = q.done;

endmodule : stab_timer
`default_nettype wire

// ===== dv/clk_ctrl_assertions.sv
// Checker for the clock gating and oscillator control block
`timescale 1ns/10ps
`default_nettype none
module clk_ctrl_assertions
	import clk_ctrl_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       reset_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       stop_exec,
	input wire logic       stop_mode,
	input wire logic       main_osc_enable,
	input wire logic       main_ext_clk_gate,
	input wire logic       int_hs_osc_enable,
	input wire logic       subsys_osc_enable,
	input wire logic [1:0] cpu_source,
	input wire logic [1:0] subsys_pin_port_in,
	input wire logic [7:0] periph_clk_gate,
	input wire logic       periph_on_subclk,
	input wire logic       adc_i2c_unguaranteed
);
	// *****
	// Checks
	// *****
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	chk_gate_follows:
	assert property (reg_wr && reg_addr == ADDR_PER_EN
		|=> periph_clk_gate == $past(reg_wdata))
	else $error("gate differs from written enables");
	chk_gate_holds:
	assert property (!(reg_wr && reg_addr == ADDR_PER_EN)
		|=> $stable(periph_clk_gate))
	else $error("gate changed without a write");
	chk_enable_readback:
	assert property (reg_rd && reg_addr == ADDR_PER_EN
		|=> reg_rdata == periph_clk_gate)
	else $error("enable readback differs from gate");
	chk_main_stop_bit:
	assert property (reg_wr && reg_addr == ADDR_OP_STAT
		&& reg_wdata[MAIN_STOP_BIT] |=> !main_osc_enable)
	else $error("main oscillator runs with stop bit set");
	chk_stop_entry:
	assert property (stop_exec |=> stop_mode)
	else $error("stop instruction did not enter stop");
	chk_stop_halts:
	assert property (stop_mode |-> !main_osc_enable && !main_ext_clk_gate)
	else $error("main clock alive in stop");
	chk_int_stop:
	assert property (reg_wr && reg_addr == ADDR_OP_STAT
		&& reg_wdata[HIO_STOP_BIT] && cpu_source != SRC_INT_HS
		|=> !int_hs_osc_enable)
	else $error("internal oscillator not stopped");
	chk_sub_periph:
	assert property (periph_on_subclk == (cpu_source == SRC_SUB))
	else $error("peripheral clock source wrong");
	chk_unguaranteed:
	assert property (adc_i2c_unguaranteed == (periph_on_subclk
		&& (periph_clk_gate[ADC_BIT] || periph_clk_gate[I2C_BIT])))
	else $error("unguaranteed flag wrong");
	chk_pins_masked:
	assert property (subsys_osc_enable |-> subsys_pin_port_in == 2'b00)
	else $error("port input seen while oscillating");
endmodule : clk_ctrl_assertions

bind clock_gating_and_oscillator_ctrl clk_ctrl_assertions chk (
	.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .stop_exec, .stop_mode, .main_osc_enable,
	.main_ext_clk_gate, .int_hs_osc_enable, .subsys_osc_enable,
	.cpu_source, .subsys_pin_port_in, .periph_clk_gate,
	.periph_on_subclk, .adc_i2c_unguaranteed
);
`default_nettype wire

// ===== dv/xtal_model.sv
// Subsystem crystal or port source on the two subsystem pins
`timescale 1ns/10ps
`default_nettype none
module xtal_model (
	input  wire logic       run,
	input  wire logic [1:0] lvl,
	output logic            osc_in,
	output logic            osc_out
);
	// Swings only while the amplifier runs, else the pins carry port levels
	logic ph = 1'b0;
	always #37 ph = ~ph;
	assign osc_in  = run ? ph : lvl[0];
	assign osc_out = run ? ~ph : lvl[1];
endmodule : xtal_model
`default_nettype wire

// ===== dv/clock_gating_and_oscillator_ctrl_tb.sv
// Self-checking bench for the clock gating and oscillator control block
`timescale 1ns/10ps
`default_nettype none
module clock_gating_and_oscillator_ctrl_tb
	import clk_ctrl_pkg::*;
;
	logic       ref_clk, reset_n, reg_wr, reg_rd, stop_exec, wake_req;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, periph_clk_gate;
	logic [1:0] cpu_source, subsys_pin_port_in, pin_lvl;
	logic       subsys_osc_in, subsys_osc_out, stop_mode, main_osc_enable;
	logic       main_ext_clk_gate, int_hs_osc_enable, subsys_osc_enable;
	logic       periph_on_subclk, adc_i2c_unguaranteed;
	int         fails, checked;
	// Short unit in simulation; wake adds the power-mode state and CPU source register stages
	localparam int SIM_UNIT = 2;
	localparam int WAKE_CYC = SIM_UNIT + 2;

	clock_gating_and_oscillator_ctrl #(.STAB_UNIT(SIM_UNIT)) dut (
		.ref_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .stop_exec, .wake_req, .subsys_osc_in,
		.subsys_osc_out, .stop_mode, .main_osc_enable,
		.main_ext_clk_gate, .int_hs_osc_enable, .subsys_osc_enable,
		.cpu_source, .subsys_pin_port_in, .periph_clk_gate,
		.periph_on_subclk, .adc_i2c_unguaranteed
	);
	xtal_model xt (.run(subsys_osc_enable), .lvl(pin_lvl),
		.osc_in(subsys_osc_in), .osc_out(subsys_osc_out));

	// *****
	// Bus and compare tasks
	// *****
	task automatic cmp(string nm, logic [7:0] exp, logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, exp, got);
		end
	endtask : cmp
	task automatic tick(int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic wr(logic [3:0] a, logic [7:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(string nm, logic [3:0] a, logic [7:0] exp);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		cmp(nm, exp, reg_rdata);
	endtask : rd
	task automatic pulse(bit wake);
		@(posedge ref_clk);
		if (wake)
			wake_req <= 1'b1;
		else
			stop_exec <= 1'b1;
		@(posedge ref_clk);
		{stop_exec, wake_req} <= 2'b00;
		#1;
	endtask : pulse

	// *****
	// Scenarios
	// *****
	task automatic t_reset();
		rd("per_en", ADDR_PER_EN, 8'h00);
		rd("op_stat", ADDR_OP_STAT, OP_STAT_RESET);
		rd("stab", ADDR_STAB_SEL, STAB_SEL_RESET);
		rd("osc_mode", ADDR_OSC_MODE, OSC_MODE_RESET);
		rd("cpu_clk", ADDR_CPU_CLK, 8'h00);
		cmp("src", 8'h00, {6'h00, cpu_source});
		cmp("pins", 8'h03, {6'h00, subsys_pin_port_in});
		pin_lvl <= 2'b01;
		tick(4);
		cmp("pins", 8'h01, {6'h00, subsys_pin_port_in});
		wr(ADDR_OP_STAT, 8'hc1);
		tick(1);
		cmp("hio_en", 8'h01, {7'h00, int_hs_osc_enable});
		rd("op_stat", ADDR_OP_STAT, OP_STAT_RESET);
	endtask : t_reset
	task automatic t_gate();
		for (int i = 0; i < 8; i++) begin
			wr(ADDR_PER_EN, 8'h01 << i);
			cmp("gate", 8'h01 << i, periph_clk_gate);
			rd("per_en", ADDR_PER_EN, 8'h01 << i);
		end
		wr(4'hf, 8'hff);
		rd("unmapped", 4'hf, 8'h00);
		rd("per_en", ADDR_PER_EN, 8'h80);
		wr(ADDR_PER_EN, 8'h01 << ADC_BIT);
	endtask : t_gate
	task automatic t_sub();
		wr(ADDR_OSC_MODE, 8'h10);
		rd("osc_mode", ADDR_OSC_MODE, 8'h10);
		wr(ADDR_OP_STAT, 8'h80);
		cmp("sub_en", 8'h01, {7'h00, subsys_osc_enable});
		cmp("pins", 8'h00, {6'h00, subsys_pin_port_in});
		wr(ADDR_CPU_CLK, 8'h40);
		tick(1);
		cmp("src", 8'h02, {6'h00, cpu_source});
		rd("cpu_clk", ADDR_CPU_CLK, 8'hc0);
		cmp("on_sub", 8'h01, {7'h00, periph_on_subclk});
		cmp("unguar", 8'h01, {7'h00, adc_i2c_unguaranteed});
		wr(ADDR_OP_STAT, 8'h81);
		cmp("hio_en", 8'h00, {7'h00, int_hs_osc_enable});
		wr(ADDR_OP_STAT, 8'h80);
		cmp("hio_en", 8'h01, {7'h00, int_hs_osc_enable});
	endtask : t_sub
	task automatic t_main();
		wr(ADDR_OSC_MODE, 8'h50);
		wr(ADDR_OP_STAT, 8'h00);
		cmp("main_en", 8'h01, {7'h00, main_osc_enable});
		wr(ADDR_OP_STAT, 8'h80);
		cmp("main_en", 8'h00, {7'h00, main_osc_enable});
		wr(ADDR_OP_STAT, 8'h00);
		wr(ADDR_CPU_CLK, 8'h10);
		tick(1);
		cmp("src", 8'h01, {6'h00, cpu_source});
		rd("cpu_clk", ADDR_CPU_CLK, 8'h30);
		cmp("on_sub", 8'h00, {7'h00, periph_on_subclk});
	endtask : t_main
	task automatic t_stop();
		logic [7:0] run;
		wr(ADDR_STAB_SEL, 8'h00);
		for (int i = 0; i < 2; i++) begin
			run = i ? 8'h01 : 8'h02;
			wr(ADDR_OSC_MODE, i ? 8'hd0 : 8'h50);
			cmp("clk", run, {6'h00, main_osc_enable, main_ext_clk_gate});
			pulse(1'b0);
			cmp("stop", 8'h01, {7'h00, stop_mode});
			cmp("clk", 8'h00, {6'h00, main_osc_enable,
				main_ext_clk_gate});
			pulse(1'b1);
			cmp("stop", 8'h00, {7'h00, stop_mode});
			cmp("clk", run, {6'h00, main_osc_enable, main_ext_clk_gate});
			// CPU stays on the internal clock until the wait runs out
			cmp("src", 8'h00, {6'h00, cpu_source});
			tick(WAKE_CYC - 1);
			cmp("src", 8'h00, {6'h00, cpu_source});
			tick(1);
			cmp("src", 8'h01, {6'h00, cpu_source});
		end
	endtask : t_stop

	// *****
	// Run control
	// *****
	task automatic conclude();
		if (fails == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// Whole sequence needs well under a thousand cycles
	initial begin
		#500000;
		fails++;
		conclude();
	end
	initial begin
		{reset_n, reg_wr, reg_rd, stop_exec, wake_req} = 5'h00;
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		pin_lvl = 2'b11;
		fails = 0;
		checked = 0;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		tick(4);
		t_reset();
		t_gate();
		t_sub();
		t_main();
		t_stop();
		conclude();
	end
endmodule : clock_gating_and_oscillator_ctrl_tb
`default_nettype wire
